/* File: src/dupp_pkg.sv */
// package: register map, fields, resets and carriers of the pin port
`default_nettype none
package dupp_pkg;
  localparam int NPINS = 5;
  localparam int AW    = 8;

  // printed offsets are word indexes; byte address is four times
  localparam logic [5:0] IDX_REV  = 6'h0a;
  localparam logic [5:0] IDX_CTRL = 6'h0e;
  localparam logic [5:0] IDX_OUT  = 6'h0f;
  localparam logic [5:0] IDX_IN   = 6'h10;
  localparam logic [5:0] IDX_PRE  = 6'h11;

  localparam int CTRL_ON_BIT = 7;
  localparam int DIR_LSB     = 0;
  localparam int PIN_FILTER  = 4;
  localparam int PRE_A0P_BIT = 0;
  localparam int PRE_A0N_BIT = 1;
  localparam int PRE_A1P_BIT = 2;
  localparam int PRE_A1N_BIT = 3;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] OUT_RST  = 5'h00;
  localparam logic [7:0] PRE_RST  = 8'hff;
  localparam logic [4:0] SYNC_RST = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       on;
    logic [1:0] rsvd;
    logic [4:0] dir;
  } dupp_ctrl_t;

  typedef struct packed {
    logic [4:0] oe;
    logic [4:0] level;
  } dupp_drive_t;

  typedef struct packed {
    logic       filter;
    logic [3:0] mode;
  } dupp_strap_t;

  typedef enum logic {WS_COLLECT, WS_RESP} dupp_wr_state_t;
  typedef enum logic {RS_IDLE, RS_DATA} dupp_rd_state_t;
endpackage
`default_nettype wire

/* File: src/dupp_sync.sv */
// two-stage synchroniser for the pin input levels
`default_nettype none
module dupp_sync
  import dupp_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // levels
  input  wire logic [NPINS-1:0] d_in,
  output logic      [NPINS-1:0] q_out
);
  logic [NPINS-1:0] meta_r;
  logic [NPINS-1:0] meta_nxt;
  logic [NPINS-1:0] q_r;
  logic [NPINS-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_in;
    q_nxt    = meta_r;  // first stage feeds only the second
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= SYNC_RST;
      q_r    <= SYNC_RST;
    end else if (ce) begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_out = q_r;
endmodule
`default_nettype wire

/* File: src/dupp_pin_mux.sv */
// per-pin drive and strap pass-through for the dual-use pins
`default_nettype none
module dupp_pin_mux
  import dupp_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // configuration
  input  wire logic             port_on,
  input  wire logic [NPINS-1:0] dir,
  input  wire logic [NPINS-1:0] level,
  // pins
  input  wire logic [NPINS-1:0] pad_in,
  output logic      [NPINS-1:0] pad_out,
  output logic      [NPINS-1:0] pad_oe,
  // straps to the core
  output dupp_strap_t           strap
);
  dupp_drive_t drv_r;
  dupp_drive_t drv_nxt;
  dupp_strap_t strap_r;
  dupp_strap_t strap_nxt;

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      always_comb begin
        drv_nxt.oe[i]    = port_on & dir[i];
        drv_nxt.level[i] = port_on & dir[i] & level[i];
      end
    end
  endgenerate

  // strap inputs keep following the pad level in every mode
  always_comb begin
    strap_nxt.filter = pad_in[PIN_FILTER];
    strap_nxt.mode   = pad_in[3:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_r   <= '0;
      strap_r <= '0;
    end else if (ce) begin
      drv_r   <= drv_nxt;
      strap_r <= strap_nxt;
    end
  end

  assign pad_out = drv_r.level;
  assign pad_oe  = drv_r.oe;
  assign strap   = strap_r;
endmodule
`default_nettype wire

/* File: src/dupp_regs_top.sv */
// dual-use pin port registers with an AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
module dupp_regs_top
  import dupp_pkg::*;
#(
  // arbitrary neutral value, not a real part's code
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  // clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // write address
  input  wire logic [AW-1:0]    s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // read address
  input  wire logic [AW-1:0]    s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // control-mode strap level
  input  wire logic             spi_ctrl_mode,
  // dual-use pins
  input  wire logic [NPINS-1:0] pad_in,
  output logic      [NPINS-1:0] pad_out,
  output logic      [NPINS-1:0] pad_oe,
  // straps to the converter core
  output dupp_strap_t           strap,
  // analog input precharge buffers
  output logic                  ain0_pos_buffer_on,
  output logic                  ain0_neg_buffer_on,
  output logic                  ain1_pos_buffer_on,
  output logic                  ain1_neg_buffer_on
);

  // write channel state
  dupp_wr_state_t wr_state_r;
  dupp_wr_state_t wr_state_nxt;
  logic           aw_held_r;
  logic           aw_held_nxt;
  logic           w_held_r;
  logic           w_held_nxt;
  logic [AW-1:0]  awaddr_r;
  logic [AW-1:0]  awaddr_nxt;
  logic [7:0]     wbyte_r;
  logic [7:0]     wbyte_nxt;
  logic           wlane_r;
  logic           wlane_nxt;
  logic [1:0]     bresp_r;
  logic [1:0]     bresp_nxt;

  // read channel state
  dupp_rd_state_t rd_state_r;
  dupp_rd_state_t rd_state_nxt;
  logic [31:0]    rdata_r;
  logic [31:0]    rdata_nxt;
  logic [1:0]     rresp_r;
  logic [1:0]     rresp_nxt;

  // registers
  dupp_ctrl_t     ctrl_r;
  dupp_ctrl_t     ctrl_nxt;
  logic [4:0]     outv_r;
  logic [4:0]     outv_nxt;
  logic [7:0]     pre_r;
  logic [7:0]     pre_nxt;

  // internal
  logic             aw_fire;
  logic             w_fire;
  logic             ar_fire;
  logic             wr_go;
  logic [5:0]       wr_idx;
  logic [5:0]       rd_idx;
  logic             port_on;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] pin_in_value;

  // handshake outputs are combinational from state
  assign s_axi_awready = ce & (wr_state_r == WS_COLLECT) & ~aw_held_r;
  assign s_axi_wready  = ce & (wr_state_r == WS_COLLECT) & ~w_held_r;
  assign s_axi_arready = ce & (rd_state_r == RS_IDLE);
  assign s_axi_bvalid  = (wr_state_r == WS_RESP);
  assign s_axi_rvalid  = (rd_state_r == RS_DATA);
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  // write commits one cycle after both halves are held
  assign wr_go   = (wr_state_r == WS_COLLECT) & aw_held_r & w_held_r;
  assign wr_idx  = awaddr_r[AW-1:2];
  assign rd_idx  = s_axi_araddr[AW-1:2];

  // outside serial-control mode the port stays dead whatever is stored
  assign port_on = ctrl_r.on & spi_ctrl_mode;

  // output pins and pins of a disabled port read back as zero
  assign pin_in_value = pin_sync & ~ctrl_r.dir & {NPINS{port_on}};

  // write channel
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_held_nxt  = aw_held_r;
    w_held_nxt   = w_held_r;
    awaddr_nxt   = awaddr_r;
    wbyte_nxt    = wbyte_r;
    wlane_nxt    = wlane_r;
    bresp_nxt    = bresp_r;
    case (wr_state_r)
      WS_COLLECT: begin
        if (aw_fire) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt  = s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_nxt = 1'b1;
          wbyte_nxt  = s_axi_wdata[7:0];
          wlane_nxt  = s_axi_wstrb[0];
        end
        if (wr_go) begin
          aw_held_nxt  = 1'b0;
          w_held_nxt   = 1'b0;
          wr_state_nxt = WS_RESP;
          if (wr_idx == IDX_CTRL) begin
            bresp_nxt = RESP_OKAY;
          end else if (wr_idx == IDX_OUT) begin
            bresp_nxt = RESP_OKAY;
          end else if (wr_idx == IDX_PRE) begin
            bresp_nxt = RESP_OKAY;
          end else begin
            // read-only and unmapped words refuse the write
            bresp_nxt = RESP_SLVERR;
          end
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          wr_state_nxt = WS_COLLECT;
        end
      end
      default: begin
        wr_state_nxt = WS_COLLECT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= WS_COLLECT;
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= '0;
      wbyte_r    <= 8'h00;
      wlane_r    <= 1'b0;
      bresp_r    <= RESP_OKAY;
    end else if (ce) begin
      wr_state_r <= wr_state_nxt;
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      awaddr_r   <= awaddr_nxt;
      wbyte_r    <= wbyte_nxt;
      wlane_r    <= wlane_nxt;
      bresp_r    <= bresp_nxt;
    end
  end

  // register file; a cleared lane 0 strobe leaves the word unchanged
  always_comb begin
    ctrl_nxt = ctrl_r;
    outv_nxt = outv_r;
    pre_nxt  = pre_r;
    if (wr_go && wlane_r) begin
      if (wr_idx == IDX_CTRL) begin
        ctrl_nxt.on   = wbyte_r[CTRL_ON_BIT];
        ctrl_nxt.rsvd = 2'h0;
        ctrl_nxt.dir  = wbyte_r[DIR_LSB +: NPINS];
      end else if (wr_idx == IDX_OUT) begin
        outv_nxt = wbyte_r[NPINS-1:0];
      end else if (wr_idx == IDX_PRE) begin
        pre_nxt = ~wbyte_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      outv_r <= OUT_RST;
      pre_r  <= PRE_RST;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      outv_r <= outv_nxt;
      pre_r  <= pre_nxt;
    end
  end

  // read channel
  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    case (rd_state_r)
      RS_IDLE: begin
        if (ar_fire) begin
          rd_state_nxt = RS_DATA;
          rresp_nxt    = RESP_OKAY;
          if (rd_idx == IDX_REV) begin
            rdata_nxt = {24'h000000, REVISION_CODE};
          end else if (rd_idx == IDX_CTRL) begin
            rdata_nxt = {24'h000000, ctrl_r};
          end else if (rd_idx == IDX_OUT) begin
            rdata_nxt = {27'h0000000, outv_r};
          end else if (rd_idx == IDX_IN) begin
            rdata_nxt = {27'h0000000, pin_in_value};
          end else if (rd_idx == IDX_PRE) begin
            rdata_nxt = {24'h000000, pre_r};
          end else begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = RESP_SLVERR;
          end
        end
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          rd_state_nxt = RS_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= RS_IDLE;
      rdata_r    <= 32'h00000000;
      rresp_r    <= RESP_OKAY;
    end else if (ce) begin
      rd_state_r <= rd_state_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // precharge buffer enables straight from the stored byte
  assign ain0_pos_buffer_on = pre_r[PRE_A0P_BIT];
  assign ain0_neg_buffer_on = pre_r[PRE_A0N_BIT];
  assign ain1_pos_buffer_on = pre_r[PRE_A1P_BIT];
  assign ain1_neg_buffer_on = pre_r[PRE_A1N_BIT];

  // pin levels are asynchronous to the bus clock in practice
  dupp_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d_in    (pad_in),
    .q_out   (pin_sync)
  );

  dupp_pin_mux u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .port_on (port_on),
    .dir     (ctrl_r.dir),
    .level   (outv_r),
    .pad_in  (pad_in),
    .pad_out (pad_out),
    .pad_oe  (pad_oe),
    .strap   (strap)
  );

endmodule
`default_nettype wire

/* File: verif/dupp_regs_assertions.sv */
// concurrent checks on the pin port register block
`default_nettype none
module dupp_regs_assertions
  import dupp_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             ce,
  // read bus
  input wire logic [AW-1:0]    s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_bvalid,
  // pins and buffers
  input wire logic             spi_ctrl_mode,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_out,
  input wire logic [NPINS-1:0] pad_oe,
  input wire dupp_strap_t      strap,
  input wire logic             ain0_pos_buffer_on,
  input wire logic             ain0_neg_buffer_on,
  input wire logic             ain1_pos_buffer_on,
  input wire logic             ain1_neg_buffer_on
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [3:0] bufs = {ain1_neg_buffer_on, ain1_pos_buffer_on,
                           ain0_neg_buffer_on, ain0_pos_buffer_on};
  wire logic       ar_take = s_axi_arvalid && s_axi_arready;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_gate_a: assert property (!$past(spi_ctrl_mode) |-> pad_oe == '0)
    else $error("pin driven outside serial control");
  no_drive_a: assert property ((pad_out & ~pad_oe) == '0)
    else $error("level on undriven pin");
  // a low clock enable freezes the strap copy, so only enabled edges count
  strap_follow_a: assert property ($past(aresetn) && $past(ce) |-> strap == $past(pad_in))
    else $error("strap does not follow pin");
  reset_state_a: assert property ($rose(aresetn) |-> pad_oe == '0 && bufs == 4'hf)
    else $error("bad state after reset");
  rev_read_a: assert property (ar_take && s_axi_araddr[7:2] == IDX_REV |=>
    s_axi_rvalid && s_axi_rdata == {24'h0, REVISION_CODE} && s_axi_rresp == RESP_OKAY)
    else $error("bad revision read");
  in_read_a: assert property (ar_take && s_axi_araddr[7:2] == IDX_IN |=>
    s_axi_rdata[31:5] == '0 && s_axi_rresp == RESP_OKAY)
    else $error("bad input value read");
  pre_quiet_a: assert property (!$stable(bufs) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("buffer enable moved without a write");
  rd_answer_a: assert property ($rose(s_axi_rvalid) |-> $past(ar_take))
    else $error("read answer without request");
endmodule

bind dupp_regs_top dupp_regs_assertions #(.REVISION_CODE(REVISION_CODE)) u_chk (
  .aclk, .aresetn, .ce, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .spi_ctrl_mode, .pad_in, .pad_out,
  .pad_oe, .strap, .ain0_pos_buffer_on, .ain0_neg_buffer_on, .ain1_pos_buffer_on,
  .ain1_neg_buffer_on
);
`default_nettype wire

/* File: verif/dupp_board.sv */
// board logic sitting on the dual-use pins
`default_nettype none
module dupp_board
  import dupp_pkg::*;
(
  // board's own levels
  input  wire logic [NPINS-1:0] brd_level,
  // device side
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe,
  // resolved pin levels
  output logic      [NPINS-1:0] pad_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // board straps are weak, so a driving device wins
  assign pad_wire = (pad_oe & pad_out) | (~pad_oe & brd_level);
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the pin port register block
`default_nettype none
module tb
  import dupp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary value
  localparam logic [7:0] REV_CODE = 8'h3c;
  logic             aclk, aresetn, ce, spi_ctrl_mode;
  logic [AW-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [2:0]       s_axi_awprot, s_axi_arprot;
  logic [31:0]      s_axi_wdata, s_axi_rdata, v;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [NPINS-1:0] pad_in, pad_out, pad_oe, brd_level;
  dupp_strap_t      strap;
  logic             ain0_pos_buffer_on, ain0_neg_buffer_on;
  logic             ain1_pos_buffer_on, ain1_neg_buffer_on;
  logic [7:0]       ctrl_m, out_m, pre_m;
  int               error_cnt, num_checks, seed;

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

  dupp_regs_top #(.REVISION_CODE(REV_CODE)) dut (.*);
  dupp_board u_brd (.brd_level(brd_level), .pad_out(pad_out), .pad_oe(pad_oe),
                    .pad_wire(pad_in));

  always #2.5 aclk = ~aclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("MISMATCH t=%0t bus timeout", $time);
    close_out();
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic       ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    hb = 1'b0;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!hb) hang();
    `CHK(r, er)
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic        ha, hb;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    hb = 1'b0;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hb = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!hb) hang();
    `CHK(d, {24'h0, ed})
    `CHK(r, er)
  endtask

  function automatic logic [4:0] oe_exp();
    return (ctrl_m[CTRL_ON_BIT] && spi_ctrl_mode) ? ctrl_m[4:0] : 5'h00;
  endfunction

  function automatic logic [4:0] in_exp();
    return (ctrl_m[CTRL_ON_BIT] && spi_ctrl_mode) ? brd_level & ~ctrl_m[4:0] : 5'h00;
  endfunction

  task automatic pins();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    `CHK(pad_oe, oe_exp())
    `CHK(pad_out, oe_exp() & out_m[4:0])
    `CHK(strap, (oe_exp() & out_m[4:0]) | (~oe_exp() & brd_level))
    `CHK({ain1_neg_buffer_on, ain1_pos_buffer_on, ain0_neg_buffer_on, ain0_pos_buffer_on},
         pre_m[3:0])
  endtask

  initial begin
    {aclk, aresetn, spi_ctrl_mode, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, brd_level} = '0;
    ce          = 1'b1;
    s_axi_wstrb = 4'hf;
    seed        = 32'hbdca;
    ctrl_m      = 8'h00;
    out_m       = 8'h00;
    pre_m       = 8'hff;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_REV, REV_CODE, RESP_OKAY);
    rd(IDX_CTRL, 8'h00, RESP_OKAY);
    rd(IDX_OUT, 8'h00, RESP_OKAY);
    rd(IDX_IN, 8'h00, RESP_OKAY);
    rd(IDX_PRE, 8'hff, RESP_OKAY);
    rd(6'h3f, 8'h00, RESP_SLVERR);
    wr(IDX_REV, 8'hff, RESP_SLVERR);
    wr(IDX_IN, 8'hff, RESP_SLVERR);
    rd(IDX_REV, REV_CODE, RESP_OKAY);
    wr(IDX_PRE, 8'h01, RESP_OKAY);
    pre_m = 8'hfe;
    rd(IDX_PRE, 8'hfe, RESP_OKAY);
    // a cleared lane 0 strobe is answered but stores nothing
    s_axi_wstrb <= 4'he;
    wr(IDX_OUT, 8'h1f, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(IDX_OUT, 8'h00, RESP_OKAY);
    $display("test map_and_reset done");
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      spi_ctrl_mode <= (i < 2) ? 1'b0 : v[7];
      brd_level     <= v[4:0];
      ctrl_m = (i < 4) ? 8'h9f : v[15:8] & 8'h9f;
      out_m  = v[23:16] & 8'h1f;
      pre_m  = ~v[31:24];
      wr(IDX_CTRL, ctrl_m | v[14:13] << 5, RESP_OKAY);
      wr(IDX_OUT, v[23:16], RESP_OKAY);
      wr(IDX_PRE, v[31:24], RESP_OKAY);
      pins();
      rd(IDX_CTRL, ctrl_m, RESP_OKAY);
      rd(IDX_OUT, out_m, RESP_OKAY);
      rd(IDX_PRE, pre_m, RESP_OKAY);
      rd(IDX_IN, {3'h0, in_exp()}, RESP_OKAY);
    end
    $display("test random_pins done");
    // all pins inputs, then a level change just before a read
    spi_ctrl_mode <= 1'b1;
    ctrl_m = 8'h80;
    wr(IDX_CTRL, 8'h80, RESP_OKAY);
    brd_level <= 5'h15;
    repeat (3) @(posedge aclk);
    rd(IDX_IN, 8'h15, RESP_OKAY);
    brd_level <= 5'h0a;
    rd(IDX_IN, 8'h15, RESP_OKAY);
    rd(IDX_IN, 8'h0a, RESP_OKAY);
    // enable low must hold the strap copy against a pin change
    ce        <= 1'b0;
    brd_level <= 5'h15;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    `CHK(strap, 5'h0a)
    ce <= 1'b1;
    pins();
    $display("test sync_and_enable done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, 8'h00, RESP_OKAY);
    rd(IDX_PRE, 8'hff, RESP_OKAY);
    $display("test second_reset done");
    close_out();
  end
endmodule
`default_nettype wire
